// *** rtl/tmcs_top.sv ***
// per-channel maintenance control and live defect status
// assumes plain register port and line pins sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
`include "tmcs_params.svh"
module tmcs_top #(
  parameter int AIS_WINDOW_CYC = `TMCS_AIS_WINDOW_CYC
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // register port
  input  wire logic [`TMCS_ADDR_W-1:0]   addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output logic      [7:0]                rdata,
  // configuration
  input  wire tmcs_pkg::tmcs_line_code_t line_code,
  input  wire logic                      rx_polarity_select,
  input  wire logic                      frame_loss_to_ais_select,
  input  wire logic                      global_reset,
  // line pins
  input  wire logic                      line_receive_clock,
  input  wire logic                      positive_rail_in,
  input  wire logic                      negative_rail_in,
  input  wire logic                      line_alarm_input_pin,
  // internal datapath
  input  wire logic                      coder_pos,
  input  wire logic                      coder_neg,
  input  wire logic                      decoder_data,
  input  wire logic                      pattern_gen_data,
  output logic                           decoder_in_pos,
  output logic                           decoder_in_neg,
  output logic                           decoder_in_clk,
  output logic                           coder_in_data,
  output logic                           channel_in_reset,
  // fault inputs
  input  wire logic                      desync_fault,
  input  wire logic                      map_error,
  input  wire logic                      multiframe_loss,
  input  wire logic                      rx_justif_ovf,
  input  wire logic                      gen_justif_ovf,
  input  wire logic                      violation_ovf,
  // status out
  output logic                           loss_of_signal
);
  import tmcs_pkg::*;

  logic [7:0] ctrl_q;
  logic [3:0] pin_s;
  logic       lrclk_q;
  logic       lrclk_rise;
  logic       los_d;
  logic [7:0] quiet_q;
  logic [7:0] pos_q;
  logic [7:0] ones_q;
  logic       ais;
  logic       bit_one;
  logic [7:0] status;
  logic       tlb;
  logic       flb;

  function automatic logic is_reserved(input logic [`TMCS_ADDR_W-1:0] a);
    is_reserved = (a >= `TMCS_OFS_RSVD_LO) && (a <= `TMCS_OFS_RSVD_HI);
  endfunction

  // alarm pin shares the line synchroniser
  tmcs_sync3 #(.W(4)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .d     ({line_alarm_input_pin, line_receive_clock, positive_rail_in, negative_rail_in}),
    .q     (pin_s)
  );

  assign tlb     = ctrl_q[`TMCS_BIT_TLB];
  assign flb     = ctrl_q[`TMCS_BIT_FLB];
  assign bit_one = pin_s[1] | pin_s[0];

  // control register; reserved low bits forced to zero
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q <= `TMCS_CTRL_RESET;
    end else if (wr_stb && addr == `TMCS_OFS_CTRL) begin
      ctrl_q <= wdata & `TMCS_CTRL_WMASK;
    end
  end

  // read path; status reads touch nothing else
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (addr == `TMCS_OFS_CTRL) begin
        rdata <= ctrl_q;
      end else if (addr == `TMCS_OFS_STATUS) begin
        rdata <= status;
      end else if (is_reserved(addr)) begin
        rdata <= 8'h00;
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // datapath steering
  always_ff @(posedge clock) begin
    if (!nrst) begin
      decoder_in_pos   <= 1'b0;
      decoder_in_neg   <= 1'b0;
      decoder_in_clk   <= 1'b0;
      coder_in_data    <= 1'b0;
      channel_in_reset <= 1'b1;
    end else begin
      channel_in_reset <= ctrl_q[`TMCS_BIT_RST] | global_reset;
      if (tlb) begin
        decoder_in_pos <= coder_pos;
        decoder_in_neg <= coder_neg;
        decoder_in_clk <= lrclk_rise;
      end else begin
        decoder_in_pos <= pin_s[1];
        decoder_in_neg <= pin_s[0];
        decoder_in_clk <= lrclk_rise;
      end
      if (ctrl_q[`TMCS_BIT_SPAT]) begin
        coder_in_data <= pattern_gen_data;
      end else if (flb) begin
        coder_in_data <= decoder_data;
      end else begin
        coder_in_data <= decoder_data;
      end
    end
  end

  // line clock edge finder on the synchronised level
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lrclk_q <= 1'b0;
    end else begin
      lrclk_q <= pin_s[2];
    end
  end
  assign lrclk_rise = pin_s[2] & ~lrclk_q;

  // loss of signal: quiet run to enter, ones density to leave
  always_comb begin
    los_d = loss_of_signal;
    if (line_code == TMCS_CODE_NRZ) begin
      los_d = 1'b0;
    end else if (lrclk_rise) begin
      if (!loss_of_signal && !bit_one && quiet_q == 8'(`TMCS_LOS_WINDOW - 1)) begin
        los_d = 1'b1;
      end else if (loss_of_signal && pos_q == 8'(`TMCS_LOS_WINDOW - 1)) begin
        los_d = ~((ones_q + {7'h00, bit_one}) >= 8'(`TMCS_LOS_ONES_MIN));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      loss_of_signal <= 1'b0;
      quiet_q        <= '0;
      pos_q          <= '0;
      ones_q         <= '0;
    end else begin
      loss_of_signal <= los_d;
      if (line_code == TMCS_CODE_NRZ || channel_in_reset) begin
        quiet_q <= '0;
        pos_q   <= '0;
        ones_q  <= '0;
      end else if (lrclk_rise) begin
        quiet_q <= bit_one ? 8'h00 : (quiet_q == 8'hff ? quiet_q : quiet_q + 8'h01);
        if (pos_q == 8'(`TMCS_LOS_WINDOW - 1)) begin
          pos_q  <= '0;
          ones_q <= '0;
        end else begin
          pos_q  <= pos_q + 8'h01;
          ones_q <= ones_q + {7'h00, bit_one};
        end
      end
    end
  end

  tmcs_ais_det #(.WINDOW_CYC(AIS_WINDOW_CYC), .ZERO_MAX(`TMCS_AIS_ZERO_MAX)) u_ais (
    .clock   (clock),
    .nrst    (nrst),
    .bit_stb (lrclk_rise),
    .bit_one (bit_one),
    .ais     (ais)
  );

  // live status, assembled combinationally
  always_comb begin
    status    = 8'h00;
    status[7] = pin_s[3] ^ rx_polarity_select;
    status[6] = desync_fault;
    status[5] = loss_of_signal;
    status[4] = frame_loss_to_ais_select ? multiframe_loss : map_error;
    status[3] = ais;
    status[2] = rx_justif_ovf;
    status[1] = gen_justif_ovf;
    status[0] = violation_ovf;
  end
endmodule
`default_nettype wire

// *** common/tmcs_params.svh ***
// constants for the tributary maintenance control and status block
// assumes a 10 MHz system clock and an 8-bit register port
`ifndef TMCS_PARAMS_SVH
`define TMCS_PARAMS_SVH

`define TMCS_ADDR_W          8
`define TMCS_OFS_CTRL        8'h0c
`define TMCS_OFS_RSVD_LO     8'h0d
`define TMCS_OFS_RSVD_HI     8'h0f
`define TMCS_OFS_STATUS      8'h10
`define TMCS_CTRL_RESET      8'h00
`define TMCS_CTRL_WMASK      8'hf0
`define TMCS_BIT_TLB         7
`define TMCS_BIT_FLB         6
`define TMCS_BIT_RST         5
`define TMCS_BIT_SPAT        4
`define TMCS_LOS_WINDOW      175
`define TMCS_LOS_ONES_MIN    22
`define TMCS_CLK_HZ          10000000
`define TMCS_AIS_WINDOW_MS   3
`define TMCS_AIS_WINDOW_CYC  ((`TMCS_CLK_HZ / 1000) * `TMCS_AIS_WINDOW_MS)
`define TMCS_AIS_ZERO_MAX    2

`endif

// *** common/tmcs_pkg.sv ***
// types for the tributary maintenance control and status block
// assumes tmcs_params.svh for all numeric constants
package tmcs_pkg;
  typedef logic [7:0] tmcs_byte_t;
  typedef enum logic [1:0] {TMCS_MAP_ASYNC, TMCS_MAP_BSYNC, TMCS_MAP_MBSYNC} tmcs_map_mode_t;
  typedef enum logic [1:0] {TMCS_CODE_AMI, TMCS_CODE_B8ZS, TMCS_CODE_NRZ} tmcs_line_code_t;
endpackage

// *** rtl/tmcs_sync3.sv ***
// three-stage synchroniser for pins from outside the clock domain
// assumes level inputs; output moves once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module tmcs_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/tmcs_ais_det.sv ***
// ds1 ais detector over a fixed window of system clocks
// assumes one pulse per line bit, data valid with it
`timescale 1ns/10ps
`default_nettype none
`include "tmcs_params.svh"
module tmcs_ais_det #(
  parameter int WINDOW_CYC = `TMCS_AIS_WINDOW_CYC,
  parameter int ZERO_MAX   = `TMCS_AIS_ZERO_MAX
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // line bits
  input  wire logic bit_stb,
  input  wire logic bit_one,
  // state
  output logic      ais
);
  logic [31:0] tick_q;
  logic [15:0] zeros_q;
  logic [15:0] bits_q;

  // a window is "all ones" when it saw at least one bit and no more than ZERO_MAX zeros
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tick_q  <= '0;
      zeros_q <= '0;
      bits_q  <= '0;
      ais     <= 1'b0;
    end else if (tick_q == 32'(WINDOW_CYC - 1)) begin
      tick_q  <= '0;
      zeros_q <= '0;
      bits_q  <= '0;
      ais     <= (bits_q != '0) && (zeros_q <= 16'(ZERO_MAX));
    end else begin
      tick_q <= tick_q + 32'd1;
      if (bit_stb) begin
        bits_q <= bits_q + 16'd1;
        if (!bit_one && zeros_q != 16'hffff) begin
          zeros_q <= zeros_q + 16'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/tmcs_props.sv ***
// checker for the maintenance control and status block
// assumes tmcs_pkg compiled first; bound to every tmcs_top
`timescale 1ns/10ps
`default_nettype none
module tmcs_props (
  // clock, reset and register port
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  // datapath and status
  input wire logic       global_reset,
  input wire logic       decoder_data,
  input wire logic       pattern_gen_data,
  input wire logic       coder_in_data,
  input wire logic       channel_in_reset,
  input wire logic       desync_fault,
  input wire logic       loss_of_signal
);
  import tmcs_pkg::*;
  logic [7:0] ctrl_sh_q;
  logic       free_run;
  default clocking
    @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // control byte as the design should hold it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_sh_q <= 8'h00;
    end else if (wr_stb && addr == 8'h0c) begin
      ctrl_sh_q <= wdata & 8'hf0;
    end
  end
  assign free_run = !ctrl_sh_q[5] && !global_reset && !channel_in_reset;
  AST_CTRL_RB: assert property (rd_stb && addr == 8'h0c |=> rdata == $past(ctrl_sh_q))
    else $error("control readback wrong");
  AST_RSVD: assert property (rd_stb && addr != 8'h0c && addr != 8'h10 |=> rdata == 8'h00)
    else $error("reserved read not zero");
  AST_IDLE: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_DMAP: assert property (rd_stb && addr == 8'h10 |=> rdata[6] == $past(desync_fault))
    else $error("demap fault bit wrong");
  AST_LOS: assert property (rd_stb && addr == 8'h10 |=> rdata[5] == $past(loss_of_signal))
    else $error("signal loss bit wrong");
  AST_CHRST: assert property (1'b1 |=> channel_in_reset == $past(ctrl_sh_q[5] | global_reset))
    else $error("channel reset hold wrong");
  AST_SPAT: assert property (free_run && ctrl_sh_q[4] |=> coder_in_data == $past(pattern_gen_data))
    else $error("pattern not substituted");
  AST_FAC: assert property (free_run && !ctrl_sh_q[4] |=> coder_in_data == $past(decoder_data))
    else $error("decoder data not passed");
  cover property (rd_stb && addr == 8'h10 ##1 rdata[5]);
  cover property ($rose(loss_of_signal));
  cover property (free_run && ctrl_sh_q[4]);
endmodule
bind tmcs_top tmcs_props props_i (
  .clock (clock), .nrst (nrst), .addr (addr), .wdata (wdata), .wr_stb (wr_stb),
  .rd_stb (rd_stb), .rdata (rdata), .global_reset (global_reset),
  .decoder_data (decoder_data), .pattern_gen_data (pattern_gen_data),
  .coder_in_data (coder_in_data), .channel_in_reset (channel_in_reset),
  .desync_fault (desync_fault), .loss_of_signal (loss_of_signal)
);
`default_nettype wire

// *** bench/tmcs_line_model.sv ***
// line interface partner: line clock and ami rails
// assumes the bench sets run and ones between frames
`timescale 1ns/10ps
`default_nettype none
module tmcs_line_model (
  // control from bench
  input  wire logic run,
  input  wire logic ones,
  // line pins
  output logic      line_receive_clock,
  output logic      positive_rail_in,
  output logic      negative_rail_in
);
  logic mark;
  initial begin
    {line_receive_clock, positive_rail_in, negative_rail_in, mark} = '0;
    forever begin
      #400;
      // clock stands still outside frames
      line_receive_clock = run & ~line_receive_clock;
      if (!line_receive_clock) begin
        positive_rail_in = ones & run & ~mark;
        negative_rail_in = ones & run & mark;
        mark = mark ^ ones;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/tmcs_top_tb.sv ***
// self-checking bench for tmcs_top
// assumes tmcs_line_model drives the line clock and rails; the bench drives the alarm pin
`timescale 1ns/10ps
`default_nettype none
module tmcs_top_tb;
  import tmcs_pkg::*;
  logic            clock, nrst, wr_stb, rd_stb, run, ones, rx_polarity_select;
  logic [7:0]      addr, wdata, rdata;
  tmcs_line_code_t line_code;
  logic            frame_loss_to_ais_select, global_reset, line_receive_clock;
  logic            positive_rail_in, negative_rail_in, line_alarm_input_pin, coder_pos;
  logic            coder_neg, decoder_data, pattern_gen_data, decoder_in_pos, decoder_in_neg;
  logic            decoder_in_clk, coder_in_data, channel_in_reset, desync_fault, map_error;
  logic            multiframe_loss, rx_justif_ovf, gen_justif_ovf, violation_ovf, loss_of_signal;
  int              error_cnt, checks_done;
  tmcs_top #(.AIS_WINDOW_CYC(200)) DUT (
    .clock (clock), .nrst (nrst), .addr (addr), .wdata (wdata), .wr_stb (wr_stb),
    .rd_stb (rd_stb), .rdata (rdata), .line_code (line_code),
    .rx_polarity_select (rx_polarity_select),
    .frame_loss_to_ais_select (frame_loss_to_ais_select), .global_reset (global_reset),
    .line_receive_clock (line_receive_clock), .positive_rail_in (positive_rail_in),
    .negative_rail_in (negative_rail_in), .line_alarm_input_pin (line_alarm_input_pin),
    .coder_pos (coder_pos), .coder_neg (coder_neg), .decoder_data (decoder_data),
    .pattern_gen_data (pattern_gen_data), .decoder_in_pos (decoder_in_pos),
    .decoder_in_neg (decoder_in_neg), .decoder_in_clk (decoder_in_clk),
    .coder_in_data (coder_in_data), .channel_in_reset (channel_in_reset),
    .desync_fault (desync_fault), .map_error (map_error),
    .multiframe_loss (multiframe_loss), .rx_justif_ovf (rx_justif_ovf),
    .gen_justif_ovf (gen_justif_ovf), .violation_ovf (violation_ovf),
    .loss_of_signal (loss_of_signal)
  );
  tmcs_line_model line_i (
    .run (run), .ones (ones), .line_receive_clock (line_receive_clock),
    .positive_rail_in (positive_rail_in), .negative_rail_in (negative_rail_in)
  );
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    {addr, rd_stb} <= {a, 1'b1};
    cyc(1);
    rd_stb <= 1'b0;
    chk(rdata, exp);
  endtask
  task automatic t_ctrl();
    rd(8'h0c, 8'h00);
    wr(8'h0c, 8'hb0);
    rd(8'h0c, 8'hb0);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    rd(8'h0c, 8'hb0);
    wr(8'h0c, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_status();
    logic [7:0] tbl [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h40, 8'h80};
    for (int i = 0; i < 6; i++) begin
      {line_alarm_input_pin, desync_fault, map_error, rx_justif_ovf, gen_justif_ovf,
       violation_ovf} <= 6'h01 << i;
      // alarm pin needs the synchroniser delay
      cyc(3);
      rd(8'h10, tbl[i]);
      rd(8'h10, tbl[i]);
    end
    {line_alarm_input_pin, map_error, rx_polarity_select, frame_loss_to_ais_select} <= 4'h7;
    cyc(3);
    rd(8'h10, 8'h80);
    multiframe_loss <= 1'b1;
    rd(8'h10, 8'h90);
    {map_error, rx_polarity_select, frame_loss_to_ais_select, multiframe_loss} <= 4'h0;
  endtask
  task automatic t_paths();
    wr(8'h0c, 8'h80);
    {coder_pos, coder_neg} <= 2'b11;
    cyc(2);
    chk(decoder_in_pos, 1'b1);
    chk(decoder_in_neg, 1'b1);
    wr(8'h0c, 8'h90);
    {pattern_gen_data, decoder_data} <= 2'b10;
    cyc(2);
    chk(coder_in_data, 1'b1);
    wr(8'h0c, 8'h40);
    cyc(2);
    chk(coder_in_data, 1'b0);
    wr(8'h0c, 8'h20);
    cyc(2);
    chk(channel_in_reset, 1'b1);
    wr(8'h0c, 8'h00);
    global_reset <= 1'b1;
    cyc(2);
    chk(channel_in_reset, 1'b1);
    global_reset <= 1'b0;
    cyc(2);
    chk(channel_in_reset, 1'b0);
  endtask
  task automatic t_los();
    logic [7:0] n;
    run <= 1'b1;
    cyc(2100);
    rd(8'h10, 8'h20);
    // one decoder strobe per line clock period of 8 system clocks
    n = 8'h00;
    repeat (80) begin
      cyc(1);
      n = n + {7'h00, decoder_in_clk};
    end
    chk(n, 8'h0a);
    ones <= 1'b1;
    cyc(4100);
    rd(8'h10, 8'h08);
    {ones, line_code} <= {1'b0, TMCS_CODE_NRZ};
    cyc(2100);
    rd(8'h10, 8'h00);
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {nrst, wr_stb, rd_stb, run, ones, addr, wdata, rx_polarity_select, coder_neg} = '0;
    {frame_loss_to_ais_select, global_reset, line_alarm_input_pin, coder_pos} = '0;
    {decoder_data, pattern_gen_data, desync_fault, map_error, multiframe_loss} = '0;
    {rx_justif_ovf, gen_justif_ovf, violation_ovf, error_cnt, checks_done} = '0;
    line_code = TMCS_CODE_AMI;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_ctrl();
    t_status();
    t_paths();
    t_los();
    give_verdict();
  end
endmodule
`default_nettype wire
